// ---- hdl/ccls_top.sv ----
// Design decisions made here: the register addresses and the Wishbone register port.
module ccls_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [15:0] instr_i,
  input wire logic pcc_mode_cap_i,
  input wire ccls_pkg::ccls_cap_t ddc_i,
  output logic [4:0] cap_raddr_o,
  input wire ccls_pkg::ccls_cap_t cap_rdata_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output ccls_pkg::ccls_req_t req_o,
  output ccls_pkg::ccls_flt_t flt_o
);
  import ccls_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [2:0] ctrl_q;
  logic flt_stk_q;
  logic misal_stk_q;
  logic ill_stk_q;
  logic [4:0] last_cause_q;
  logic [31:0] fcnt_q;
  logic [31:0] fadr_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic out_valid_q;
  ccls_req_t req_q;
  ccls_flt_t flt_q;

  logic rv64;
  logic f_en;
  logic d_en;
  logic cap_mode;
  logic [1:0] quad;
  logic [2:0] f3;
  logic sp_rel;
  logic [4:0] rd_full;
  logic [4:0] rd_c;
  logic [4:0] rs1_c;
  ccls_op_t op;
  logic [9:0] imm;
  logic [4:0] size;
  ccls_cap_t auth;
  logic [63:0] sum;
  logic [63:0] eff_addr;
  logic chk_fault;
  logic [4:0] chk_cause;
  logic misal;
  logic take;
  logic any_fault;
  logic wb_req;
  logic wb_wr;

  // ----------------------------------------
  // Field helpers
  // ----------------------------------------
  // Offset of word forms, register-based or stack-based
  function automatic logic [9:0] imm_word(input logic [15:0] ins, input logic sp);
    logic [9:0] v;
    v = 10'h0;
    if (sp) begin
      v = {2'h0, ins[3:2], ins[12], ins[6:4], 2'h0};
    end else begin
      v = {3'h0, ins[5], ins[12:10], ins[6], 2'h0};
    end
    return v;
  endfunction

  // Offset of doubleword forms, also rv32 capability loads
  function automatic logic [9:0] imm_dbl(input logic [15:0] ins, input logic sp);
    logic [9:0] v;
    v = 10'h0;
    if (sp) begin
      v = {1'b0, ins[4:2], ins[12], ins[6:5], 3'h0};
    end else begin
      v = {2'h0, ins[6:5], ins[12:10], 3'h0};
    end
    return v;
  endfunction

  // Offset of 16-byte capability loads on 64-bit harts
  function automatic logic [9:0] imm_cap64(input logic [15:0] ins, input logic sp);
    logic [9:0] v;
    v = 10'h0;
    if (sp) begin
      v = {ins[5:2], ins[12], ins[6], 4'h0};
    end else begin
      v = {1'b0, ins[10], ins[6:5], ins[12:11], 4'h0};
    end
    return v;
  endfunction

  // ----------------------------------------
  // Configuration and mode
  // ----------------------------------------
  assign rv64 = ctrl_q[CTRL_RV64];
  assign f_en = ctrl_q[CTRL_FEN];
  assign d_en = ctrl_q[CTRL_DEN];
  assign cap_mode = pcc_mode_cap_i;
  assign quad = instr_i[1:0];
  assign f3 = instr_i[15:13];
  assign sp_rel = (quad == QUAD_C2);
  assign rd_full = instr_i[11:7];
  assign rd_c = {CREG_HI, instr_i[4:2]};
  assign rs1_c = {CREG_HI, instr_i[9:7]};

  // ----------------------------------------
  // Decode with mode remapping
  // ----------------------------------------
  always_comb begin
    op = OP_NONE;
    if (quad == QUAD_C0 || quad == QUAD_C2) begin
      unique case (f3)
        F3_LW: op = OP_LW;
        F3_LD: begin
          // 64-bit: doubleword; 32-bit: capability or single float
          if (rv64) begin
            op = OP_LD;
          end else if (cap_mode) begin
            op = OP_LC;
          end else begin
            op = f_en ? OP_FLW : OP_NONE;
          end
        end
        F3_FLD: begin
          if (rv64 && cap_mode) begin
            op = OP_LC;
          end else begin
            op = d_en ? OP_FLD : OP_NONE;
          end
        end
        F3_SW: op = (quad == QUAD_C0) ? OP_SW : OP_NONE;
        F3_SD: op = (quad == QUAD_C0 && rv64) ? OP_SD : OP_NONE;
        default: op = OP_NONE;
      endcase
      // Stack integer and capability loads reserve rd zero
      if (sp_rel && rd_full == 5'h0 && (op == OP_LW || op == OP_LD || op == OP_LC)) begin
        op = OP_NONE;
      end
    end
  end

  // ----------------------------------------
  // Offset and access size
  // ----------------------------------------
  always_comb begin
    imm = 10'h0;
    size = SIZE_W;
    unique case (op)
      OP_LW, OP_FLW, OP_SW: begin
        imm = imm_word(instr_i, sp_rel);
        size = SIZE_W;
      end
      OP_LD, OP_FLD, OP_SD: begin
        imm = imm_dbl(instr_i, sp_rel);
        size = SIZE_D;
      end
      OP_LC: begin
        imm = rv64 ? imm_cap64(instr_i, sp_rel) : imm_dbl(instr_i, sp_rel);
        size = rv64 ? SIZE_C64 : SIZE_D;
      end
      OP_NONE: begin
        imm = 10'h0;
        size = SIZE_W;
      end
    endcase
  end

  // ----------------------------------------
  // Authority selection
  // ----------------------------------------
  // Base register read; stack forms read register two
  assign cap_raddr_o = sp_rel ? CSP_IDX : rs1_c;

  // Capability mode takes the register, legacy the default cap
  always_comb begin
    if (cap_mode) begin
      auth = cap_rdata_i;
    end else begin
      auth = ddc_i;
    end
  end

  // Effective address, truncated on 32-bit harts
  assign sum = cap_rdata_i.addr + {54'h0, imm};
  assign eff_addr = rv64 ? sum : {32'h0, sum[31:0]};

  ccls_auth_chk u_chk (
    .cap_i(auth),
    .addr_i(eff_addr),
    .size_i(size),
    .store_i(op == OP_SW || op == OP_SD),
    .fault_o(chk_fault),
    .cause_o(chk_cause)
  );

  // Natural alignment only enforced on capability loads
  assign misal = (op == OP_LC) && ((eff_addr[4:0] & (size - 5'h01)) != 5'h0);

  assign any_fault = (op != OP_NONE) && (chk_fault || misal);

  // ----------------------------------------
  // Output handshake
  // ----------------------------------------
  assign in_ready_o = !out_valid_q || out_ready_i;
  assign take = in_valid_i && in_ready_o;
  assign out_valid_o = out_valid_q;
  assign req_o = req_q;
  assign flt_o = flt_q;

  // Valid holds until the pipeline takes it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_valid_q <= 1'b0;
    end else if (take) begin
      out_valid_q <= 1'b1;
    end else if (out_ready_i) begin
      out_valid_q <= 1'b0;
    end
  end

  // Request, checked as its expanded form would be
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_q <= '0;
    end else if (take) begin
      req_q.mem_en <= (op != OP_NONE) && !any_fault;
      req_q.op <= op;
      req_q.store <= (op == OP_SW || op == OP_SD);
      req_q.rd <= sp_rel ? rd_full : rd_c;
      req_q.addr <= eff_addr;
      req_q.size <= size;
    end
  end

  // Fault report: capability faults ahead of misalignment
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flt_q <= '0;
    end else if (take) begin
      flt_q <= '0;
      if (op == OP_NONE) begin
        flt_q.illegal <= 1'b1;
      end else if (chk_fault) begin
        flt_q.valid <= 1'b1;
        flt_q.exc <= EXC_CAP;
        flt_q.ftype <= TYPE_DATA;
        flt_q.cause <= chk_cause;
      end else if (misal) begin
        flt_q.valid <= 1'b1;
        flt_q.exc <= EXC_LD_MISAL;
      end
    end
  end

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q; // Write lands with the ack
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // One wait state, ack dropped after one cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_req;
    end
  end

  // Read mux; unmapped words read zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdat_q <= 32'h0;
    end else if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        REG_CTRL: rdat_q <= {29'h0, ctrl_q};
        REG_STAT: rdat_q <= {19'h0, last_cause_q, 5'h0, ill_stk_q, misal_stk_q, flt_stk_q};
        REG_FCNT: rdat_q <= fcnt_q;
        REG_FADR: rdat_q <= fadr_q;
        default: rdat_q <= 32'h0;
      endcase
    end
  end

  // Width and float support controls
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
    end else if (wb_wr && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
      ctrl_q <= wb_dat_i[2:0];
    end
  end

  // ----------------------------------------
  // Fault status
  // ----------------------------------------
  // Sticky flags, write one to clear, set wins
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flt_stk_q <= 1'b0;
      misal_stk_q <= 1'b0;
      ill_stk_q <= 1'b0;
    end else begin
      if (take && any_fault && chk_fault) begin
        flt_stk_q <= 1'b1;
      end else if (wb_wr && wb_adr_i == REG_STAT && wb_sel_i[0] && wb_dat_i[STAT_FLT]) begin
        flt_stk_q <= 1'b0;
      end
      if (take && any_fault && !chk_fault) begin
        misal_stk_q <= 1'b1;
      end else if (wb_wr && wb_adr_i == REG_STAT && wb_sel_i[0] && wb_dat_i[STAT_MISAL]) begin
        misal_stk_q <= 1'b0;
      end
      if (take && op == OP_NONE) begin
        ill_stk_q <= 1'b1;
      end else if (wb_wr && wb_adr_i == REG_STAT && wb_sel_i[0] && wb_dat_i[STAT_ILL]) begin
        ill_stk_q <= 1'b0;
      end
    end
  end

  // Last capability cause and faulting address
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_cause_q <= CAUSE_NONE;
      fadr_q <= 32'h0;
    end else if (take && any_fault) begin
      last_cause_q <= chk_fault ? chk_cause : CAUSE_NONE;
      fadr_q <= eff_addr[31:0];
    end
  end

  // Fault counter; any write clears, a fault in the same cycle as the write restarts it at one
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fcnt_q <= 32'h0;
    end else if (take && any_fault) begin
      if (wb_wr && wb_adr_i == REG_FCNT) begin
        fcnt_q <= 32'h1;
      end else begin
        fcnt_q <= fcnt_q + 32'h1;
      end
    end else if (wb_wr && wb_adr_i == REG_FCNT) begin
      fcnt_q <= 32'h0;
    end
  end

endmodule

// ---- hdl/ccls_pkg.sv ----
package ccls_pkg;

  // ----------------------------------------
  // Capability, request and fault carriers
  // ----------------------------------------
  typedef struct packed {
    logic tag;
    logic sealed;
    logic perm_r;
    logic perm_w;
    logic [63:0] base;
    logic [64:0] top;
    logic [63:0] addr;
  } ccls_cap_t;

  typedef enum logic [2:0] {
    OP_NONE, OP_LW, OP_LD, OP_FLW, OP_FLD, OP_LC, OP_SW, OP_SD
  } ccls_op_t;

  typedef struct packed {
    logic mem_en;
    ccls_op_t op;
    logic store;
    logic [4:0] rd;
    logic [63:0] addr;
    logic [4:0] size;
  } ccls_req_t;

  typedef struct packed {
    logic valid;
    logic illegal;
    logic [5:0] exc;
    logic [3:0] ftype;
    logic [4:0] cause;
  } ccls_flt_t;

  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  localparam logic [1:0] QUAD_C0 = 2'h0;
  localparam logic [1:0] QUAD_C2 = 2'h2;
  localparam logic [2:0] F3_FLD = 3'h1;
  localparam logic [2:0] F3_LW = 3'h2;
  localparam logic [2:0] F3_LD = 3'h3;
  localparam logic [2:0] F3_SW = 3'h6;
  localparam logic [2:0] F3_SD = 3'h7;
  localparam logic [4:0] CSP_IDX = 5'h02;
  localparam logic [1:0] CREG_HI = 2'h1;
  localparam logic [4:0] SIZE_W = 5'h04;
  localparam logic [4:0] SIZE_D = 5'h08;
  localparam logic [4:0] SIZE_C64 = 5'h10;

  // ----------------------------------------
  // Fault codes
  // ----------------------------------------
  localparam logic [4:0] CAUSE_NONE = 5'h00;
  localparam logic [4:0] CAUSE_TAG = 5'h02;
  localparam logic [4:0] CAUSE_SEAL = 5'h03;
  localparam logic [4:0] CAUSE_PERM = 5'h12;
  localparam logic [4:0] CAUSE_LEN = 5'h01;
  localparam logic [5:0] EXC_NONE = 6'h00;
  localparam logic [5:0] EXC_LD_MISAL = 6'h04;
  localparam logic [5:0] EXC_CAP = 6'h1c;
  localparam logic [3:0] TYPE_NONE = 4'h0;
  localparam logic [3:0] TYPE_DATA = 4'h1;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_FCNT = 4'h8;
  localparam logic [3:0] REG_FADR = 4'hc;
  localparam int CTRL_RV64 = 0;
  localparam int CTRL_FEN = 1;
  localparam int CTRL_DEN = 2;
  localparam logic [2:0] CTRL_RST = 3'h7;
  localparam int STAT_FLT = 0;
  localparam int STAT_MISAL = 1;
  localparam int STAT_ILL = 2;
  localparam int STAT_CAUSE = 8;

endpackage

// ---- hdl/ccls_auth_chk.sv ----
module ccls_auth_chk (
  input wire ccls_pkg::ccls_cap_t cap_i,
  input wire logic [63:0] addr_i,
  input wire logic [4:0] size_i,
  input wire logic store_i,
  output logic fault_o,
  output logic [4:0] cause_o
);
  import ccls_pkg::*;

  logic [64:0] end_addr;
  logic perm_ok;
  logic out_of_bounds;

  // ----------------------------------------
  // Authority checks
  // ----------------------------------------
  // Last byte plus one, one bit wider to catch wrap
  assign end_addr = {1'b0, addr_i} + {60'h0, size_i};
  assign perm_ok = store_i ? cap_i.perm_w : cap_i.perm_r;
  assign out_of_bounds = (addr_i < cap_i.base) || (end_addr > cap_i.top);

  // First failing check wins
  always_comb begin
    fault_o = 1'b1;
    if (!cap_i.tag) begin
      cause_o = CAUSE_TAG;
    end else if (cap_i.sealed) begin
      cause_o = CAUSE_SEAL;
    end else if (!perm_ok) begin
      cause_o = CAUSE_PERM;
    end else if (out_of_bounds) begin
      cause_o = CAUSE_LEN;
    end else begin
      fault_o = 1'b0;
      cause_o = CAUSE_NONE;
    end
  end

endmodule

// ---- tb/ccls_top_checker.sv ----
module ccls_top_checker
  import ccls_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic in_valid_i,
  input wire logic in_ready_o,
  input wire logic [15:0] instr_i,
  input wire logic pcc_mode_cap_i,
  input wire ccls_cap_t ddc_i,
  input wire logic [4:0] cap_raddr_o,
  input wire ccls_cap_t cap_rdata_i,
  input wire logic out_valid_o,
  input wire logic out_ready_i,
  input wire ccls_req_t req_o,
  input wire ccls_flt_t flt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Authority and word-form decode
  // ----------------------------------------
  ccls_cap_t auth;
  logic ld_w;
  logic st_w;
  // Authority follows the mode bit
  assign auth = pcc_mode_cap_i ? cap_rdata_i : ddc_i;
  assign ld_w = instr_i[1:0] == QUAD_C0 && instr_i[15:13] == F3_LW;
  assign st_w = instr_i[1:0] == QUAD_C0 && instr_i[15:13] == F3_SW;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    in_valid_i && in_ready_o;
  endsequence
  sequence s_live;
    auth.tag && !auth.sealed;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  wb_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack is not a single pulse");
  answer_next_a: assert property (s_take |=> out_valid_o)
    else $error("no result after take");
  hold_out_a: assert property (out_valid_o && !out_ready_i |=>
    out_valid_o && $stable(req_o) && $stable(flt_o)) else $error("result moved while stalled");
  sp_index_a: assert property (in_valid_i && instr_i[1:0] == QUAD_C2 |->
    cap_raddr_o == CSP_IDX) else $error("stack forms not reading register two");
  base_index_a: assert property (in_valid_i && instr_i[1:0] == QUAD_C0 |->
    cap_raddr_o == {CREG_HI, instr_i[9:7]}) else $error("wrong base register index");
  tag_fault_a: assert property (s_take ##0 ((ld_w || st_w) && !auth.tag) |=>
    flt_o.valid && flt_o.cause == CAUSE_TAG) else $error("tag fault missing");
  seal_fault_a: assert property (s_take ##0 ((ld_w || st_w) && auth.tag &&
    auth.sealed) |=> flt_o.cause == CAUSE_SEAL) else $error("seal fault missing");
  read_perm_a: assert property (s_take ##0 ld_w ##0 s_live ##0 !auth.perm_r |=>
    flt_o.cause == CAUSE_PERM) else $error("read permission fault missing");
  write_perm_a: assert property (s_take ##0 st_w ##0 s_live ##0 !auth.perm_w |=>
    flt_o.cause == CAUSE_PERM) else $error("write permission fault missing");
  fault_type_a: assert property (out_valid_o && flt_o.exc == EXC_CAP |->
    flt_o.valid && flt_o.ftype == TYPE_DATA) else $error("fault type not data");
  no_access_a: assert property (out_valid_o && (flt_o.valid || flt_o.illegal) |->
    !req_o.mem_en) else $error("access not suppressed");
  misal_only_a: assert property (out_valid_o && flt_o.exc == EXC_LD_MISAL |->
    req_o.op == OP_LC && flt_o.cause == CAUSE_NONE) else $error("bad misaligned report");
endmodule

bind ccls_top ccls_top_checker u_props (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .in_valid_i, .in_ready_o, .instr_i,
  .pcc_mode_cap_i, .ddc_i, .cap_raddr_o, .cap_rdata_i, .out_valid_o, .out_ready_i,
  .req_o, .flt_o
);

// ---- tb/ccls_hart_model.sv ----
module ccls_hart_model (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic [4:0] cap_raddr_i,
  output ccls_pkg::ccls_cap_t cap_rdata_o,
  output logic out_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import ccls_pkg::*;
  ccls_cap_t regs_q [32];
  logic tog_q = 1'b0;
  // Capability file read in the same cycle
  assign cap_rdata_o = regs_q[cap_raddr_i];
  // Pipeline takes every cycle, or every other one when slow
  always_ff @(posedge clk_i) begin
    tog_q <= ~tog_q;
  end
  assign out_ready_o = !slow_i || tog_q;
  initial begin
    foreach (regs_q[i]) regs_q[i] = '0;
  end
  // Register two holds the stack capability
  task automatic set_cap(input int i, input ccls_cap_t c);
    regs_q[i] = c;
  endtask
endmodule

// ---- tb/ccls_tb_top.sv ----
module ccls_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ccls_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk_i = 1'b0, rst_i = 1'b1, slow = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic in_valid_i = 1'b0, in_ready_o, pcc_mode_cap_i = 1'b0, out_valid_o, out_ready_i;
  logic [15:0] instr_i = 16'h0;
  logic [4:0] cap_raddr_o;
  ccls_cap_t ddc_i = '0, cap_rdata_i, good, bad;
  ccls_req_t req_o, r_req;
  ccls_flt_t flt_o, r_flt;
  int n_mismatch = 0, n_tests = 0;
  logic [3:0] t_flg [6] = '{4'h3, 4'hf, 4'h9, 4'hb, 4'h5, 4'hd};
  logic [63:0] t_adr [6] = '{64'h1100, 64'h1100, 64'h1100, 64'h1ff8, 64'h1100, 64'h1100};
  logic [4:0] t_cau [6] = '{CAUSE_TAG, CAUSE_SEAL, CAUSE_PERM, CAUSE_LEN, CAUSE_TAG, CAUSE_SEAL};
  ccls_top DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .in_valid_i, .in_ready_o, .instr_i, .pcc_mode_cap_i,
    .ddc_i, .cap_raddr_o, .cap_rdata_i, .out_valid_o, .out_ready_i, .req_o, .flt_o);
  ccls_hart_model hart (.clk_i, .slow_i(slow), .cap_raddr_i(cap_raddr_o),
    .cap_rdata_o(cap_rdata_i), .out_ready_o(out_ready_i));
  // Free-running clock
  initial forever #5 clk_i = ~clk_i;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] c0(input logic [2:0] f, s, d, hi, input logic [1:0] lo);
    return {f, hi, s, lo, d, QUAD_C0};
  endfunction
  function automatic logic [15:0] c2(input logic [2:0] f, input logic b, input logic [4:0] d, im);
    return {f, b, d, im, QUAD_C2};
  endfunction
  function automatic ccls_cap_t mk(input logic [3:0] f, input logic [63:0] a);
    return '{f[3], f[2], f[1], f[0], 64'h1000, 65'h2000, a};
  endfunction
  function automatic ccls_req_t rq(input ccls_op_t o, input logic [4:0] r, input logic [63:0] a,
    input logic [4:0] s);
    return '{1'b1, o, 1'b0, r, a, s};
  endfunction
  function automatic ccls_flt_t fl(input logic [4:0] c);
    return '{1'b1, 1'b0, EXC_CAP, TYPE_DATA, c};
  endfunction
  task automatic give_verdict();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic bad_i, input string what);
    n_tests++;
    if (bad_i !== 1'b0) begin
      n_mismatch++;
      $display("[FAIL] %0t %s differs", $time, what);
    end
  endtask
  task automatic cmp_req(input ccls_req_t g, e); check(g !== e, "request"); endtask
  task automatic cmp_flt(input ccls_flt_t g, e); check(g !== e, "fault"); endtask
  task automatic cmp_d(input logic [31:0] g, e); check(g !== e, "value"); endtask
  task automatic guard(inout int n);
    n++;
    if (n > 1000) begin
      check(1'b1, "timeout");
      give_verdict();
    end
  endtask
  // Classic bus cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      guard(n);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // Hand one instruction over and capture its result
  task automatic issue(input logic [15:0] ins, input logic m, input ccls_cap_t d);
    int n = 0;
    @(posedge clk_i);
    in_valid_i <= 1'b1;
    instr_i <= ins;
    pcc_mode_cap_i <= m;
    ddc_i <= d;
    #1;
    while (in_ready_o !== 1'b1) begin
      @(posedge clk_i);
      #1;
      guard(n);
    end
    @(posedge clk_i);
    in_valid_i <= 1'b0;
    #1;
    r_req = req_o;
    r_flt = flt_o;
  endtask
  task automatic dec(input logic [15:0] ins, input logic m, input ccls_op_t op);
    issue(ins, m, good);
    cmp_d(32'(r_req.op), 32'(op));
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] q;
    logic [15:0] lw;
    good = mk(4'hb, 64'h0);
    bad = mk(4'h3, 64'h0);
    lw = c0(F3_LW, 3'h1, 3'h2, 3'h1, 2'b10);
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, REG_CTRL, 32'h0, q);
    cmp_d(q, 32'h7);
    wb(1'b0, 4'h2, 32'h0, q);
    cmp_d(q, 32'h0);
    wb(1'b1, REG_FCNT, 32'h0, q);
    hart.set_cap(9, mk(4'hb, 64'h1100));
    issue(lw, 1'b1, bad);
    cmp_req(r_req, rq(OP_LW, 5'h0a, 64'h110c, SIZE_W));
    for (int i = 0; i < 6; i++) begin
      hart.set_cap(9, mk(4'hb, t_adr[i]));
      issue(lw, 1'b0, mk(t_flg[i], 64'h0));
      cmp_flt(r_flt, fl(t_cau[i]));
    end
    wb(1'b0, REG_FCNT, 32'h0, q);
    cmp_d(q, 32'h6);
    wb(1'b0, REG_FADR, 32'h0, q);
    cmp_d(q, 32'h110c);
    hart.set_cap(9, mk(4'ha, 64'h1100));
    issue(c0(F3_SW, 3'h1, 3'h2, 3'h1, 2'b10), 1'b1, good);
    cmp_flt(r_flt, fl(CAUSE_PERM));
    hart.set_cap(9, mk(4'hb, 64'h1100));
    issue(c0(F3_SW, 3'h1, 3'h2, 3'h1, 2'b10), 1'b0, good);
    cmp_d({r_req.mem_en, r_req.store, r_req.op}, {2'b11, OP_SW});
    hart.set_cap(2, mk(4'hb, 64'h1200));
    issue(c2(F3_LW, 1'b0, 5'h05, 5'h04), 1'b1, bad);
    cmp_req(r_req, rq(OP_LW, 5'h05, 64'h1204, SIZE_W));
    hart.set_cap(2, mk(4'h3, 64'h1200));
    issue(c2(F3_LW, 1'b0, 5'h05, 5'h04), 1'b0, good);
    cmp_req(r_req, rq(OP_LW, 5'h05, 64'h1204, SIZE_W));
    hart.set_cap(2, mk(4'hb, 64'h1200));
    issue(c2(3'h1, 1'b1, 5'h03, 5'h11), 1'b1, bad);
    cmp_req(r_req, rq(OP_LC, 5'h03, 64'h1270, SIZE_C64));
    issue(c2(3'h1, 1'b1, 5'h00, 5'h11), 1'b1, good);
    cmp_d({31'h0, r_flt.illegal}, 32'h1);
    hart.set_cap(9, mk(4'hb, 64'h1108));
    issue(c0(3'h1, 3'h1, 3'h2, 3'h2, 2'b00), 1'b1, good);
    cmp_d({26'h0, r_flt.exc}, {26'h0, EXC_LD_MISAL});
    hart.set_cap(9, mk(4'hb, 64'h1100));
    slow <= 1'b1;
    dec(c0(3'h1, 3'h1, 3'h2, 3'h1, 2'b00), 1'b0, OP_FLD);
    dec(c0(F3_LD, 3'h1, 3'h2, 3'h1, 2'b00), 1'b0, OP_LD);
    dec(c0(F3_LD, 3'h1, 3'h2, 3'h1, 2'b00), 1'b1, OP_LD);
    wb(1'b1, REG_CTRL, 32'h2, q);
    dec(c0(F3_LD, 3'h1, 3'h2, 3'h1, 2'b00), 1'b0, OP_FLW);
    dec(c0(F3_LD, 3'h1, 3'h2, 3'h1, 2'b00), 1'b1, OP_LC);
    dec(c2(F3_LD, 1'b0, 5'h03, 5'h04), 1'b0, OP_FLW);
    dec(c2(F3_LD, 1'b0, 5'h03, 5'h09), 1'b1, OP_LC);
    cmp_d(r_req.addr[31:0], 32'h1248);
    issue(c0(3'h1, 3'h1, 3'h2, 3'h1, 2'b00), 1'b0, good);
    cmp_d({31'h0, r_flt.illegal}, 32'h1);
    wb(1'b1, REG_CTRL, 32'h6, q);
    dec(c0(3'h1, 3'h1, 3'h2, 3'h1, 2'b00), 1'b1, OP_FLD);
    wb(1'b0, REG_STAT, 32'h0, q);
    cmp_d({29'h0, q[2:0]}, 32'h7);
    wb(1'b1, REG_STAT, 32'h7, q);
    wb(1'b0, REG_STAT, 32'h0, q);
    cmp_d({29'h0, q[2:0]}, 32'h0);
    give_verdict();
  end
endmodule
